// file: include/trip_guard_pkg.sv
// Overview of operation
// - External trip enters trip state, shows code 12, removes output drive.
// - External trip fires only on an OFF-to-ON edge of its input.
// - Trip stays latched after input goes OFF; falling edge does nothing.
// - Recorded trip events stay in history until a power cycle.
// - Trip leaves by reset or power cycle (guard trip also by run OFF), into stop, hold or run per run and guard.
// - Trip during run coasts the motor and raises alarm at once.
// - Without guard, reset clears alarm; release with run active resumes running, except after undervoltage trip 9 cleared by reset terminal.
// - Any of five inputs becomes external trip when its code is 12.
// - With guard on, cleared trip needs run edge, keypad reset or reset terminal.
// - Guard off and run active at power-up: start running at once.
// - Guard on and run active at power-up: no start, trip code 13.
// - Guard trip clears on run OFF, reset pulse or keypad stop/reset.
// - Code 13 maps the guard enable onto an input.
// - Guard trip cleared by reset terminal with run active restarts at once.
// - After undervoltage trip 9 cleared by reset, guard check still applies.
// - Per-input polarity setting inverts each input before decoding.
package trip_guard_pkg;
  localparam int NUM_INPUTS = 5;
  localparam int CODE_W = 5;
  localparam int ERR_W = 5;
  localparam logic [CODE_W-1:0] FUNC_EXT_TRIP = 5'h0C;
  localparam logic [CODE_W-1:0] FUNC_START_GUARD = 5'h0D;
  localparam logic [ERR_W-1:0] ERR_NONE = 5'h00;
  localparam logic [ERR_W-1:0] ERR_UNDERVOLT = 5'h09;
  localparam logic [ERR_W-1:0] ERR_EXT_TRIP = 5'h0C;
  localparam logic [ERR_W-1:0] ERR_START_GUARD = 5'h0D;
  localparam logic [7:0] HIST_RESET = 8'h00;
  localparam logic [7:0] ONE_HIST = 8'h01;
  // Power-up check waits out the three synchroniser stages and the filter flop
  localparam logic [2:0] PWR_UP_AT = 3'h4;
  localparam logic [2:0] PWR_UP_DONE = 3'h5;
  // Register map over the plain port
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_FUNC0 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_POLARITY = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_HISTORY = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_KEYPAD = 4'h8;
  localparam logic [CODE_W-1:0] FUNC_RESET_VAL = 5'h00;
  localparam logic [NUM_INPUTS-1:0] POL_RESET_VAL = 5'h00;
  typedef enum logic [3:0] {
    ST_STOP = 4'b0001,
    ST_RUN = 4'b0010,
    ST_TRIP = 4'b0100,
    ST_HOLD = 4'b1000
  } drive_state_t;
endpackage : trip_guard_pkg

// file: design/input_sync.sv
`timescale 1ns/1ps
module input_sync
  import trip_guard_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Raw and clean levels
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] clean_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  wire logic [W-1:0] agree = ~(s2_reg ^ s3_reg);
  // Level changes only when the last two stages agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      clean_out <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      clean_out <= (agree & s2_reg) | (~agree & clean_out);
    end
  end
endmodule : input_sync

// file: design/power_up_pulse.sv
`timescale 1ns/1ps
module power_up_pulse
  import trip_guard_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Event
  output logic power_up
);
  logic [2:0] seen_reg;
  // Fires once the clean levels carry the pins, so run and guard are valid at the check
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      seen_reg <= 3'h0;
    end else if (seen_reg != PWR_UP_DONE) begin
      seen_reg <= seen_reg + 3'h1;
    end
  end
  assign power_up = (seen_reg == PWR_UP_AT);
endmodule : power_up_pulse

// file: design/external_trip_start_guard.sv
`timescale 1ns/1ps
module external_trip_start_guard
  import trip_guard_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Terminal pins
  input wire logic [NUM_INPUTS-1:0] term_in,
  input wire logic run_cmd,
  input wire logic reset_terminal,
  input wire logic undervolt_fault,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Drive status
  output logic drive_enable,
  output logic alarm_out,
  output logic [ERR_W-1:0] error_code,
  output logic [3:0] drive_state
);
  // ****************************************
  // Input conditioning
  // ****************************************
  wire logic [NUM_INPUTS-1:0] term_clean;
  wire logic run_clean;
  wire logic rst_clean;
  wire logic power_up;
  input_sync #(.W(NUM_INPUTS)) u_term_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw_in(term_in),
    .clean_out(term_clean)
  );
  input_sync #(.W(2)) u_ctl_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw_in({run_cmd, reset_terminal}),
    .clean_out({run_clean, rst_clean})
  );
  wire logic uv_clean;
  input_sync #(.W(1)) u_uv_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw_in(undervolt_fault),
    .clean_out(uv_clean)
  );
  power_up_pulse u_pwr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .power_up(power_up)
  );

  // ****************************************
  // Registers
  // ****************************************
  logic [CODE_W-1:0] func_reg [NUM_INPUTS];
  logic [NUM_INPUTS-1:0] pol_reg;
  logic [7:0] hist_reg;
  logic [7:0] hist_next;
  logic [ERR_W-1:0] last_err_reg;

  function automatic logic func_active(input logic [CODE_W-1:0] code,
                                       input logic [NUM_INPUTS-1:0] lvl,
                                       input logic [CODE_W-1:0] map [NUM_INPUTS]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      if (map[i] == code && lvl[i]) hit = 1'b1;
    end
    return hit;
  endfunction : func_active

  // The map is passed in so a remap alone re-evaluates the decode
  wire logic [NUM_INPUTS-1:0] term_lvl = term_clean ^ pol_reg;
  wire logic ext_lvl = func_active(FUNC_EXT_TRIP, term_lvl, func_reg);
  wire logic guard_on = func_active(FUNC_START_GUARD, term_lvl, func_reg);

  wire logic wr_func = reg_wr && (reg_addr < 4'(NUM_INPUTS));
  wire logic wr_pol = reg_wr && (reg_addr == OFS_POLARITY);
  wire logic key_reset = reg_wr && (reg_addr == OFS_KEYPAD) && reg_wdata[0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_INPUTS; i++) func_reg[i] <= FUNC_RESET_VAL;
      pol_reg <= POL_RESET_VAL;
    end else begin
      if (wr_func) func_reg[reg_addr[2:0]] <= reg_wdata[CODE_W-1:0];
      if (wr_pol) pol_reg <= reg_wdata[NUM_INPUTS-1:0];
    end
  end

  // ****************************************
  // Edge detection
  // ****************************************
  logic ext_prev_reg;
  logic run_prev_reg;
  logic rst_prev_reg;
  logic uv_prev_reg;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ext_prev_reg <= 1'b0;
      run_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b0;
      uv_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_lvl;
      run_prev_reg <= run_clean;
      rst_prev_reg <= rst_clean;
      uv_prev_reg <= uv_clean;
    end
  end
  wire logic ext_rise = ext_lvl && !ext_prev_reg;
  wire logic run_rise = run_clean && !run_prev_reg;
  wire logic run_fall = !run_clean && run_prev_reg;
  wire logic rst_rise = rst_clean && !rst_prev_reg;
  wire logic uv_rise = uv_clean && !uv_prev_reg;
  // Reset clears as it is asserted; drive stays off until the terminal is released
  wire logic clear_act = rst_rise || key_reset;
  wire logic reset_held = rst_clean;

  // ****************************************
  // Drive state machine
  // ****************************************
  // Hold means an armed run is blocked until a fresh start action.
  drive_state_t state_reg;
  drive_state_t state_next;
  logic [ERR_W-1:0] err_reg;
  logic [ERR_W-1:0] err_next;
  logic guard_check_reg;
  logic guard_check_next;

  always_comb begin
    state_next = state_reg;
    err_next = err_reg;
    guard_check_next = guard_check_reg;
    case (state_reg)
      ST_STOP, ST_RUN, ST_HOLD: begin
        if (ext_rise) begin
          state_next = ST_TRIP;
          err_next = ERR_EXT_TRIP;
        end else if (uv_rise) begin
          state_next = ST_TRIP;
          err_next = ERR_UNDERVOLT;
        end else if (power_up || guard_check_reg) begin
          guard_check_next = 1'b0;
          if (run_clean && guard_on) begin
            state_next = ST_TRIP;
            err_next = ERR_START_GUARD;
          end else if (run_clean && !reset_held) begin
            state_next = ST_RUN;
          end
        end else if (state_reg == ST_HOLD) begin
          if (!run_clean) state_next = ST_STOP;
          else if (run_rise || clear_act) state_next = ST_RUN;
        end else if (state_reg == ST_RUN) begin
          if (!run_clean) state_next = ST_STOP;
        end else if (run_rise && !reset_held) begin
          state_next = ST_RUN;
        end
      end
      ST_TRIP: begin
        if (err_reg == ERR_START_GUARD && run_fall) begin
          state_next = ST_STOP;
          err_next = ERR_NONE;
        end else if (clear_act) begin
          err_next = ERR_NONE;
          if (err_reg == ERR_UNDERVOLT) begin
            state_next = ST_STOP;
            guard_check_next = 1'b1;
          end else if (err_reg == ERR_START_GUARD && run_clean) begin
            state_next = ST_RUN;
          end else if (guard_on && run_clean) begin
            state_next = ST_HOLD;
          end else if (run_clean) begin
            state_next = ST_RUN;
          end else begin
            state_next = ST_STOP;
          end
        end
      end
      default: begin
        state_next = ST_STOP;
        err_next = ERR_NONE;
      end
    endcase
  end

  wire logic trip_entry = (state_next == ST_TRIP) && (state_reg != ST_TRIP);
  always_comb begin
    hist_next = hist_reg;
    if (trip_entry && hist_reg != 8'hFF) hist_next = hist_reg + ONE_HIST;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_STOP;
      err_reg <= ERR_NONE;
      guard_check_reg <= 1'b0;
      hist_reg <= HIST_RESET;
      last_err_reg <= ERR_NONE;
    end else begin
      state_reg <= state_next;
      err_reg <= err_next;
      guard_check_reg <= guard_check_next;
      hist_reg <= hist_next;
      if (trip_entry) last_err_reg <= err_next;
    end
  end

  // ****************************************
  // Outputs and read port
  // ****************************************
  // Reset terminal held ON also removes drive, as a power-cycle reset would; a keypad reset does not
  assign drive_enable = (state_reg == ST_RUN) && !reset_held;
  assign alarm_out = (state_reg == ST_TRIP);
  assign error_code = err_reg;
  assign drive_state = state_reg;

  wire logic [7:0] status_word = {alarm_out, drive_enable, guard_on, err_reg};
  wire logic [7:0] rd_mux =
    (reg_addr < 4'(NUM_INPUTS)) ? {3'h0, func_reg[reg_addr[2:0]]} :
    (reg_addr == OFS_POLARITY) ? {3'h0, pol_reg} :
    (reg_addr == OFS_STATUS) ? status_word :
    (reg_addr == OFS_HISTORY) ? hist_reg :
    (reg_addr == OFS_KEYPAD) ? {3'h0, last_err_reg} : 8'h00;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_ext_edge;
    ext_lvl && !ext_prev_reg && state_reg != ST_TRIP;
  endsequence
  a_ext_trip_latch: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_ext_edge |=> alarm_out && error_code == ERR_EXT_TRIP && !drive_enable)
    else $error("external edge did not trip");
  a_no_fall_trip: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!ext_lvl && ext_prev_reg && !alarm_out && !uv_rise && !power_up
     && !guard_check_reg) |=> !alarm_out)
    else $error("falling edge tripped");
  a_trip_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    (alarm_out && !clear_act && !run_fall) |=> alarm_out)
    else $error("trip released without reset");
  a_alarm_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
    alarm_out |-> !drive_enable)
    else $error("drive while tripped");
  a_hist_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    (trip_entry && hist_reg != 8'hFF) |=> hist_reg == $past(hist_reg) + ONE_HIST)
    else $error("history not recorded");
  a_guard_trip: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((power_up || guard_check_reg) && run_clean && guard_on && state_reg != ST_TRIP
     && !ext_rise && !uv_rise) |=> error_code == ERR_START_GUARD && !drive_enable)
    else $error("guard did not block power-up run");
  a_no_guard_run: assert property (@(posedge sys_clk) disable iff (!nrst)
    (power_up && run_clean && !guard_on && !reset_held && state_reg == ST_STOP
     && !ext_rise && !uv_rise) |=> drive_enable)
    else $error("power-up run not started");
  a_guard_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state_reg == ST_TRIP && err_reg == ERR_START_GUARD && run_fall) |=> !alarm_out)
    else $error("guard trip not cleared by run off");
  a_power_once: assert property (@(posedge sys_clk) disable iff (!nrst)
    power_up |=> !power_up [*8])
    else $error("power-up pulse repeated");
  a_hist_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !trip_entry |=> hist_reg == $past(hist_reg))
    else $error("history changed without a trip");
  a_reset_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    (alarm_out && rst_rise) |=> !alarm_out && error_code == ERR_NONE)
    else $error("reset did not clear the trip");
  a_reset_resume: assert property (@(posedge sys_clk) disable iff (!nrst)
    (alarm_out && rst_rise && run_clean && err_reg == ERR_EXT_TRIP && !guard_on)
    |=> state_reg == ST_RUN)
    else $error("run not resumed after reset");
  sequence s_hold_quiet;
    state_reg == ST_HOLD && run_clean && !ext_rise && !uv_rise
    && !power_up && !guard_check_reg;
  endsequence
  a_hold_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_hold_quiet ##0 (!run_rise && !clear_act) |=> state_reg == ST_HOLD)
    else $error("held run started on its own");
  a_hold_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_hold_quiet ##0 clear_act |=> state_reg == ST_RUN)
    else $error("held run not started by reset");
  sequence s_uv_clear;
    alarm_out && err_reg == ERR_UNDERVOLT && clear_act;
  endsequence
  a_uv_recheck: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_uv_clear |=> guard_check_reg && state_reg == ST_STOP)
    else $error("guard check not rerun after undervoltage");
  a_guard_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    (alarm_out && err_reg == ERR_START_GUARD && rst_rise && run_clean) |=> state_reg == ST_RUN)
    else $error("guard trip reset did not restart");
  a_guard_key_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    (alarm_out && err_reg == ERR_START_GUARD && key_reset) |=> !alarm_out)
    else $error("keypad did not clear guard trip");
endmodule : external_trip_start_guard

// file: bench/operator_panel.sv
`timescale 1ns/1ps
module operator_panel (
  // Clock
  input wire logic sys_clk,
  // Requests from the operator
  input wire logic [4:0] want_term,
  input wire logic want_run,
  input wire logic want_reset,
  input wire logic want_uv,
  // Contacts seen at the terminals
  output logic [4:0] term_in,
  output logic run_cmd,
  output logic reset_terminal,
  output logic undervolt_fault
);
  // Contacts close or open one edge after the operator acts; they never float
  initial begin
    term_in = 5'h00;
    run_cmd = 1'b0;
    reset_terminal = 1'b0;
    undervolt_fault = 1'b0;
  end
  always @(posedge sys_clk) begin
    term_in <= want_term;
    // Run follows the operator request one edge later, whether or not a guard input is mapped
    run_cmd <= want_run;
    reset_terminal <= want_reset;
    undervolt_fault <= want_uv;
  end
endmodule : operator_panel

// file: bench/external_trip_start_guard_tb.sv
`timescale 1ns/1ps
module external_trip_start_guard_tb;
  import trip_guard_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] sw_term = 5'h00;
  logic sw_run = 1'b0;
  logic sw_rst = 1'b0;
  logic sw_uv = 1'b0;
  logic [NUM_INPUTS-1:0] term_in;
  logic run_cmd, reset_terminal, undervolt_fault;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic drive_enable, alarm_out;
  logic [ERR_W-1:0] error_code;
  logic [3:0] drive_state;
  logic rd_seen = 1'b0;
  logic [7:0] exp_q[$];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 74628;
  int off;

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  operator_panel i_panel (.sys_clk(sys_clk), .want_term(sw_term), .want_run(sw_run),
    .want_reset(sw_rst), .want_uv(sw_uv), .term_in(term_in), .run_cmd(run_cmd),
    .reset_terminal(reset_terminal), .undervolt_fault(undervolt_fault));

  external_trip_start_guard i_dut (.sys_clk(sys_clk), .nrst(nrst), .term_in(term_in),
    .run_cmd(run_cmd), .reset_terminal(reset_terminal), .undervolt_fault(undervolt_fault),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drive_enable(drive_enable), .alarm_out(alarm_out),
    .error_code(error_code), .drive_state(drive_state));

  // ************************************************
  // Compare and closing
  // ************************************************
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  // Read data stand only in the cycle after the strobe, so look there
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) cmp("read data unexpected", 8'h00, 8'hFF);
      else cmp("read data", exp_q.pop_front(), reg_rdata);
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      close_out();
    end
  end

  // ************************************************
  // Bus and pin tasks
  // ************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic chk(input logic [3:0] st, input logic al, input logic en,
                     input logic [4:0] err);
    @(negedge sys_clk);
    cmp("drive_state", {4'h0, st}, {4'h0, drive_state});
    cmp("alarm_out", {7'h00, al}, {7'h00, alarm_out});
    cmp("drive_enable", {7'h00, en}, {7'h00, drive_enable});
    cmp("error_code", {3'h0, err}, {3'h0, error_code});
  endtask : chk

  task automatic pulse_rst;
    sw_rst <= 1'b1;
    cyc(8);
    sw_rst <= 1'b0;
    cyc(12);
  endtask : pulse_rst

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    cyc(6);
    chk(ST_STOP, 1'b0, 1'b0, ERR_NONE);
    @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(6);
    rd(OFS_FUNC0, {3'h0, FUNC_RESET_VAL});
    rd(OFS_POLARITY, {3'h0, POL_RESET_VAL});
    rd(OFS_HISTORY, HIST_RESET);
    wr(4'hE, 8'($random(seed)));
    rd(4'hE, 8'h00);
    sw_run <= 1'b1;
    cyc(12);
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    off = {$random(seed)} % 5;
    for (int i = 0; i < 5; i++) begin
      int k;
      k = (i + off) % 5;
      wr(4'(k), {3'h0, FUNC_EXT_TRIP});
      rd(4'(k), {3'h0, FUNC_EXT_TRIP});
      sw_term[k] <= 1'b1;
      cyc(12);
      chk(ST_TRIP, 1'b1, 1'b0, ERR_EXT_TRIP);
      sw_term[k] <= 1'b0;
      cyc(12);
      chk(ST_TRIP, 1'b1, 1'b0, ERR_EXT_TRIP);
      sw_rst <= 1'b1;
      cyc(8);
      chk(ST_RUN, 1'b0, 1'b0, ERR_NONE);
      sw_rst <= 1'b0;
      cyc(12);
      chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
      wr(4'(k), 8'h00);
    end
    rd(OFS_HISTORY, 8'h05);
    rd(OFS_KEYPAD, {3'h0, ERR_EXT_TRIP});
    // Inverting an idle low input makes it read ON, which is an OFF-to-ON edge
    wr(4'h2, {3'h0, FUNC_EXT_TRIP});
    wr(OFS_POLARITY, 8'h04);
    cyc(12);
    chk(ST_TRIP, 1'b1, 1'b0, ERR_EXT_TRIP);
    wr(OFS_POLARITY, 8'h00);
    cyc(12);
    pulse_rst();
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    wr(4'h2, 8'h00);
    rd(OFS_HISTORY, 8'h06);
    // Guard on through input 1, trip on input 0
    wr(4'h0, {3'h0, FUNC_EXT_TRIP});
    wr(4'h1, {3'h0, FUNC_START_GUARD});
    sw_term[1] <= 1'b1;
    cyc(12);
    sw_term[0] <= 1'b1;
    cyc(12);
    sw_term[0] <= 1'b0;
    pulse_rst();
    chk(ST_HOLD, 1'b0, 1'b0, ERR_NONE);
    rd(OFS_STATUS, {1'b0, 1'b0, 1'b1, ERR_NONE});
    wr(OFS_KEYPAD, 8'h01);
    cyc(4);
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    sw_uv <= 1'b1;
    cyc(12);
    chk(ST_TRIP, 1'b1, 1'b0, ERR_UNDERVOLT);
    sw_uv <= 1'b0;
    pulse_rst();
    chk(ST_TRIP, 1'b1, 1'b0, ERR_START_GUARD);
    pulse_rst();
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    sw_uv <= 1'b1;
    cyc(12);
    sw_uv <= 1'b0;
    pulse_rst();
    chk(ST_TRIP, 1'b1, 1'b0, ERR_START_GUARD);
    sw_run <= 1'b0;
    cyc(12);
    chk(ST_STOP, 1'b0, 1'b0, ERR_NONE);
    sw_run <= 1'b1;
    cyc(12);
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    sw_uv <= 1'b1;
    cyc(12);
    sw_uv <= 1'b0;
    pulse_rst();
    chk(ST_TRIP, 1'b1, 1'b0, ERR_START_GUARD);
    wr(OFS_KEYPAD, 8'h01);
    cyc(4);
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    // Power cycle with run held; mapping is lost so the guard is off
    @(posedge sys_clk);
    nrst <= 1'b0;
    cyc(3);
    chk(ST_STOP, 1'b0, 1'b0, ERR_NONE);
    @(posedge sys_clk);
    nrst <= 1'b1;
    cyc(12);
    chk(ST_RUN, 1'b0, 1'b1, ERR_NONE);
    rd(OFS_HISTORY, HIST_RESET);
    cyc(4);
    close_out();
  end
endmodule : external_trip_start_guard_tb
